// File: common/act_cmd_pkg.sv
`default_nettype none
package act_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SLOT_SEL = 8'h00;
  localparam logic [7:0] OFS_GROUP_KEY = 8'h04;
  localparam logic [7:0] OFS_GROUP_MASK = 8'h08;
  localparam logic [7:0] OFS_ROLE = 8'h0C;
  localparam logic [7:0] OFS_SOURCE = 8'h10;
  localparam logic [7:0] OFS_EDGE = 8'h14;
  localparam logic [7:0] OFS_LEAD = 8'h18;
  localparam logic [7:0] OFS_UNIT_KEY = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_TS_RST = 8'h24;
  // field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DROP_BIT = 1;
  localparam int STAT_PEND_LSB = 4;
  localparam int STAT_CNT_LSB = 16;
  // slots and widths
  localparam int SLOT_COUNT = 3;
  localparam int ORIG_SLOT = 3;
  localparam int TS_RST_SLOT = 2;
  localparam int SEL_W = 4;
  localparam int KEY_W = 32;
  localparam int TIME_W = 64;
  localparam int NUM_EVENTS = 7;
  // reset values
  localparam logic [SEL_W-1:0] SLOT_SEL_RST = 4'h1;
  localparam logic [KEY_W-1:0] GROUP_KEY_RST = 32'h0;
  localparam logic [KEY_W-1:0] GROUP_MASK_RST = 32'h0;
  localparam logic [KEY_W-1:0] UNIT_KEY_RST = 32'h0;
  localparam logic [KEY_W-1:0] LEAD_RST = 32'h0;
  localparam logic EDGE_RST = 1'b1;
  // originating sources; event k is events_i[k-1]
  typedef enum logic [3:0] {
    SRC_OFF, SRC_ACCEPTED_TRIGGER, SRC_REJECTED_TRIGGER, SRC_FRAME_BEGIN,
    SRC_EXPOSURE_BEGIN, SRC_EXPOSURE_FINISH, SRC_TIMER_ONE_DONE,
    SRC_COUNTER_ONE_DONE, SRC_LINE_ONE, SRC_LINE_TWO
  } src_sel_t;
  typedef enum logic {ROLE_LISTENER, ROLE_ORIGINATOR} role_t;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage
`default_nettype wire

// File: src/origin_event_picker.sv
`timescale 1ns/1ps
`default_nettype none
module origin_event_picker
  import act_cmd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire src_sel_t source_i,
  input wire logic rise_edge_i,
  input wire logic [NUM_EVENTS-1:0] events_i,
  input wire logic line_one_i,
  input wire logic line_two_i,
  output logic fire_o
);
  logic [1:0] prev_d;
  logic [1:0] prev_q;
  logic fire_d;

  // edge of a line in the chosen direction
  function automatic logic edge_hit(input logic now, input logic prev, input logic rise);
    edge_hit = rise ? (now & ~prev) : (~now & prev);
  endfunction

  // source select and edge detection
  always_comb begin
    prev_d = {line_two_i, line_one_i};
    case (source_i)
      SRC_OFF: fire_d = 1'b0;
      SRC_LINE_ONE: fire_d = edge_hit(line_one_i, prev_q[0], rise_edge_i);
      SRC_LINE_TWO: fire_d = edge_hit(line_two_i, prev_q[1], rise_edge_i);
      default: fire_d = events_i[3'(source_i - 4'h1)];
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      // start from the present line levels so a line idling high gives no false edge
      prev_q <= prev_d;
      fire_o <= 1'b0;
    end else begin
      prev_q <= prev_d;
      fire_o <= fire_d;
    end
  end
endmodule
`default_nettype wire

// File: src/sched_wait.sv
`timescale 1ns/1ps
`default_nettype none
module sched_wait
  import act_cmd_pkg::*;
#(
  parameter int TW = TIME_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [TW-1:0] exec_time_i,
  input wire logic [TW-1:0] now_i,
  output logic fire_o,
  output logic pending_o
);
  logic pend_d;
  logic pend_q;
  logic [TW-1:0] exec_d;
  logic [TW-1:0] exec_q;

  if (TW < 1) begin : g_chk
    $error("sched_wait: time width too small");
  end

  // fires once the time has reached the stored execution time
  assign fire_o = pend_q && (now_i >= exec_q);
  assign pending_o = pend_q;

  // a new load replaces any waiting one
  always_comb begin
    pend_d = pend_q;
    exec_d = exec_q;
    if (load_i) begin
      pend_d = 1'b1;
      exec_d = exec_time_i;
    end else if (fire_o) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pend_q <= 1'b0;
      exec_q <= '0;
    end else begin
      pend_q <= pend_d;
      exec_q <= exec_d;
    end
  end
endmodule
`default_nettype wire

// File: src/action_command_control.sv
`timescale 1ns/1ps
`default_nettype none
module action_command_control
  import act_cmd_pkg::*;
#(
  parameter int NUM_SLOTS = SLOT_COUNT
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire logic [KEY_W-1:0] rx_device_key_i,
  input wire logic [KEY_W-1:0] rx_group_key_i,
  input wire logic [KEY_W-1:0] rx_group_mask_i,
  input wire logic rx_scheduled_i,
  input wire logic [TIME_W-1:0] rx_exec_time_i,
  input wire logic [TIME_W-1:0] time_now_i,
  input wire logic [NUM_EVENTS-1:0] trig_events_i,
  input wire logic input_line_one_i,
  input wire logic input_line_two_i,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [KEY_W-1:0] tx_device_key_o,
  output logic [KEY_W-1:0] tx_group_key_o,
  output logic [KEY_W-1:0] tx_group_mask_o,
  output logic tx_scheduled_o,
  output logic [TIME_W-1:0] tx_exec_time_o,
  output logic [NUM_SLOTS:1] action_pulse_o,
  output logic ts_reset_o
);
  if (NUM_SLOTS < ORIG_SLOT || NUM_SLOTS > 12) begin : g_chk
    $error("action_command_control: NUM_SLOTS out of range");
  end

  // every assertion below runs on this one clock and rests during reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // configuration state
  logic [SEL_W-1:0] sel_d, sel_q;
  logic [KEY_W-1:0] gkey_d [1:NUM_SLOTS];
  logic [KEY_W-1:0] gkey_q [1:NUM_SLOTS];
  logic [KEY_W-1:0] gmask_d [1:NUM_SLOTS];
  logic [KEY_W-1:0] gmask_q [1:NUM_SLOTS];
  role_t role_d [1:NUM_SLOTS];
  role_t role_q [1:NUM_SLOTS];
  src_sel_t src_d [1:NUM_SLOTS];
  src_sel_t src_q [1:NUM_SLOTS];
  logic edge_d [1:NUM_SLOTS];
  logic edge_q [1:NUM_SLOTS];
  logic [KEY_W-1:0] lead_d [1:NUM_SLOTS];
  logic [KEY_W-1:0] lead_q [1:NUM_SLOTS];
  logic [KEY_W-1:0] unit_key_d, unit_key_q;
  logic ts_rst_en_d, ts_rst_en_q;
  logic drop_d, drop_q;
  logic [7:0] match_cnt_d, match_cnt_q;
  logic [31:0] rdata_d;

  // listener and transmit state
  logic [NUM_SLOTS:1] hit, imm, sw_load, sw_fire, pend, pulse_d;
  logic ts_reset_d;
  tx_state_t tx_state_d, tx_state_q;
  logic [KEY_W-1:0] tx_gkey_d, tx_gmask_d;
  logic tx_sched_d;
  logic [TIME_W-1:0] tx_time_d;
  logic orig_fire, tx_start;

  // match test on a received command
  function automatic logic match_ok(
    input logic [KEY_W-1:0] dev, input logic [KEY_W-1:0] key,
    input logic [KEY_W-1:0] mask, input logic [KEY_W-1:0] unit,
    input logic [KEY_W-1:0] skey, input logic [KEY_W-1:0] smask);
    match_ok = (dev == unit) && (key == skey) && ((mask & smask) != '0);
  endfunction

  // slot register writes go to the selected slot; unit key and timestamp reset are shared
  // refused selector values keep the slot index inside the arrays
  always_comb begin
    sel_d = sel_q;
    gkey_d = gkey_q;
    gmask_d = gmask_q;
    role_d = role_q;
    src_d = src_q;
    edge_d = edge_q;
    lead_d = lead_q;
    unit_key_d = unit_key_q;
    ts_rst_en_d = ts_rst_en_q;
    if (reg_wr_i) begin
      if (reg_addr_i == OFS_SLOT_SEL) begin
        if (reg_wdata_i >= 32'h1 && reg_wdata_i <= 32'(NUM_SLOTS)) begin
          sel_d = reg_wdata_i[SEL_W-1:0];
        end
      end else if (reg_addr_i == OFS_GROUP_KEY) begin
        gkey_d[sel_q] = reg_wdata_i;
      end else if (reg_addr_i == OFS_GROUP_MASK) begin
        gmask_d[sel_q] = reg_wdata_i;
      end else if (reg_addr_i == OFS_ROLE) begin
        if (reg_wdata_i[0] && sel_q == SEL_W'(ORIG_SLOT)) begin
          role_d[sel_q] = ROLE_ORIGINATOR;
        end else begin
          role_d[sel_q] = ROLE_LISTENER;
        end
      end else if (reg_addr_i == OFS_SOURCE) begin
        if (reg_wdata_i <= 32'(SRC_LINE_TWO)) begin
          src_d[sel_q] = src_sel_t'(reg_wdata_i[3:0]);
        end
      end else if (reg_addr_i == OFS_EDGE) begin
        edge_d[sel_q] = reg_wdata_i[0];
      end else if (reg_addr_i == OFS_LEAD) begin
        lead_d[sel_q] = reg_wdata_i;
      end else if (reg_addr_i == OFS_UNIT_KEY) begin
        unit_key_d = reg_wdata_i;
      end else if (reg_addr_i == OFS_TS_RST) begin
        ts_rst_en_d = reg_wdata_i[0];
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0;
    if (reg_rd_i) begin
      if (reg_addr_i == OFS_SLOT_SEL) begin
        rdata_d[SEL_W-1:0] = sel_q;
      end else if (reg_addr_i == OFS_GROUP_KEY) begin
        rdata_d = gkey_q[sel_q];
      end else if (reg_addr_i == OFS_GROUP_MASK) begin
        rdata_d = gmask_q[sel_q];
      end else if (reg_addr_i == OFS_ROLE) begin
        rdata_d[0] = role_q[sel_q];
      end else if (reg_addr_i == OFS_SOURCE) begin
        rdata_d[3:0] = src_q[sel_q];
      end else if (reg_addr_i == OFS_EDGE) begin
        rdata_d[0] = edge_q[sel_q];
      end else if (reg_addr_i == OFS_LEAD) begin
        rdata_d = lead_q[sel_q];
      end else if (reg_addr_i == OFS_UNIT_KEY) begin
        rdata_d = unit_key_q;
      end else if (reg_addr_i == OFS_STATUS) begin
        rdata_d[STAT_BUSY_BIT] = (tx_state_q == TX_SEND);
        rdata_d[STAT_DROP_BIT] = drop_q;
        rdata_d[STAT_PEND_LSB +: NUM_SLOTS] = pend;
        rdata_d[STAT_CNT_LSB +: 8] = match_cnt_q;
      end else if (reg_addr_i == OFS_TS_RST) begin
        rdata_d[0] = ts_rst_en_q;
      end
    end
  end

  // per-slot listener: match, immediate or scheduled pulse
  // a slot set as originator never answers received commands
  for (genvar s = 1; s <= NUM_SLOTS; s++) begin : g_slot
    assign hit[s] = rx_valid_i && (role_q[s] == ROLE_LISTENER) &&
      match_ok(rx_device_key_i, rx_group_key_i, rx_group_mask_i,
               unit_key_q, gkey_q[s], gmask_q[s]);
    assign imm[s] = hit[s] && !rx_scheduled_i;
    assign sw_load[s] = hit[s] && rx_scheduled_i;
    assign pulse_d[s] = imm[s] || sw_fire[s];

    // a newer scheduled match replaces a waiting one in this slot
    sched_wait #(.TW(TIME_W)) u_wait (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .load_i(sw_load[s]),
      .exec_time_i(rx_exec_time_i),
      .now_i(time_now_i),
      .fire_o(sw_fire[s]),
      .pending_o(pend[s])
    );

    a_imm_pulse: assert property (imm[s] |=> action_pulse_o[s])
      else $error("immediate match gave no pulse");
    a_sched_pulse: assert property (sw_fire[s] |=> action_pulse_o[s])
      else $error("due schedule gave no pulse");
    a_pulse_cause: assert property (action_pulse_o[s] |-> $past(hit[s]) || $past(sw_fire[s]))
      else $error("pulse without match or due schedule");
    a_slot_filter: assert property (hit[s] |-> (rx_group_key_i == gkey_q[s])
      && ((rx_group_mask_i & gmask_q[s]) != '0) && (rx_device_key_i == unit_key_q))
      else $error("match accepted with wrong keys");
    if (s != ORIG_SLOT) begin : g_lis
      a_role_slot: assert property (role_q[s] == ROLE_LISTENER)
        else $error("originator role outside slot three");
    end
  end

  // slot two pulse may reset the timestamp
  assign ts_reset_d = ts_rst_en_q && pulse_d[TS_RST_SLOT];

  // originating event picker for the originator slot
  origin_event_picker u_pick (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .source_i(src_q[ORIG_SLOT]),
    .rise_edge_i(edge_q[ORIG_SLOT]),
    .events_i(trig_events_i),
    .line_one_i(input_line_one_i),
    .line_two_i(input_line_two_i),
    .fire_o(orig_fire)
  );

  // only the originator slot starts a request, and only when nothing is outstanding
  assign tx_start = (tx_state_q == TX_IDLE) && orig_fire && (role_q[ORIG_SLOT] == ROLE_ORIGINATOR);
  assign tx_valid_o = (tx_state_q == TX_SEND);

  // transmit request: hold until taken; events while busy are dropped
  always_comb begin
    tx_state_d = tx_state_q;
    tx_gkey_d = tx_group_key_o;
    tx_gmask_d = tx_group_mask_o;
    tx_sched_d = tx_scheduled_o;
    tx_time_d = tx_exec_time_o;
    drop_d = drop_q;
    // the clear comes first, so a drop in the same cycle still sets the flag
    if (reg_wr_i && reg_addr_i == OFS_STATUS && reg_wdata_i[STAT_DROP_BIT]) begin
      drop_d = 1'b0;
    end
    case (tx_state_q)
      TX_IDLE: begin
        if (tx_start) begin
          tx_state_d = TX_SEND;
          tx_gkey_d = gkey_q[ORIG_SLOT];
          tx_gmask_d = gmask_q[ORIG_SLOT];
          tx_sched_d = (lead_q[ORIG_SLOT] != '0);
          tx_time_d = (lead_q[ORIG_SLOT] != '0) ? time_now_i + TIME_W'(lead_q[ORIG_SLOT]) : '0;
        end
      end
      TX_SEND: begin
        if (tx_ready_i) begin
          tx_state_d = TX_IDLE;
        end
        if (orig_fire) begin
          drop_d = 1'b1;
        end
      end
      default: tx_state_d = TX_IDLE;
    endcase
  end

  // count of accepted commands
  // wraps after 255, so software should read differences
  always_comb begin
    match_cnt_d = match_cnt_q;
    if (|hit) begin
      match_cnt_d = match_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      // keys and masks start cleared, so nothing matches until software sets them
      sel_q <= SLOT_SEL_RST;
      for (int i = 1; i <= NUM_SLOTS; i++) begin
        gkey_q[i] <= GROUP_KEY_RST;
        gmask_q[i] <= GROUP_MASK_RST;
        role_q[i] <= ROLE_LISTENER;
        src_q[i] <= SRC_OFF;
        edge_q[i] <= EDGE_RST;
        lead_q[i] <= LEAD_RST;
      end
      unit_key_q <= UNIT_KEY_RST;
      ts_rst_en_q <= 1'b0;
      drop_q <= 1'b0;
      match_cnt_q <= 8'h00;
      reg_rdata_o <= 32'h0;
      action_pulse_o <= '0;
      ts_reset_o <= 1'b0;
      tx_state_q <= TX_IDLE;
      tx_group_key_o <= '0;
      tx_group_mask_o <= '0;
      tx_scheduled_o <= 1'b0;
      tx_exec_time_o <= '0;
    end else begin
      sel_q <= sel_d;
      gkey_q <= gkey_d;
      gmask_q <= gmask_d;
      role_q <= role_d;
      src_q <= src_d;
      edge_q <= edge_d;
      lead_q <= lead_d;
      unit_key_q <= unit_key_d;
      ts_rst_en_q <= ts_rst_en_d;
      drop_q <= drop_d;
      match_cnt_q <= match_cnt_d;
      reg_rdata_o <= rdata_d;
      action_pulse_o <= pulse_d;
      ts_reset_o <= ts_reset_d;
      tx_state_q <= tx_state_d;
      tx_group_key_o <= tx_gkey_d;
      tx_group_mask_o <= tx_gmask_d;
      tx_scheduled_o <= tx_sched_d;
      tx_exec_time_o <= tx_time_d;
    end
  end

  // outgoing device key follows the unit match value
  assign tx_device_key_o = unit_key_q;

  // source off for two edges with nothing outstanding
  sequence s_src_off;
    (src_q[ORIG_SLOT] == SRC_OFF) ##1 (src_q[ORIG_SLOT] == SRC_OFF) && (tx_state_q == TX_IDLE);
  endsequence
  // a request starting with zero or nonzero lead
  sequence s_start_lead(bit nz);
    tx_start && ((lead_q[ORIG_SLOT] != '0) == nz);
  endsequence

  a_off_silent: assert property (s_src_off |=> !tx_valid_o)
    else $error("request sent while source off");
  a_lead_zero: assert property (s_start_lead(1'b0) |=> tx_valid_o && !tx_scheduled_o)
    else $error("zero lead did not give immediate command");
  a_lead_add: assert property (s_start_lead(1'b1) |=> tx_scheduled_o
    && tx_exec_time_o == $past(time_now_i) + TIME_W'($past(lead_q[ORIG_SLOT])))
    else $error("scheduled time is not now plus lead");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_exec_time_o))
    else $error("request dropped before taken");
  a_drop_set: assert property ((tx_state_q == TX_SEND) && orig_fire |=> drop_q)
    else $error("event while busy not flagged as dropped");
  a_ts_reset: assert property (action_pulse_o[TS_RST_SLOT] && $past(ts_rst_en_q) |-> ts_reset_o)
    else $error("slot two pulse did not reset timestamp");
  a_key_read: assert property (reg_rd_i && reg_addr_i == OFS_UNIT_KEY |=> reg_rdata_o == $past(unit_key_q))
    else $error("unit match value read back wrong");
  a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data stood longer than one cycle");
  a_sel_range: assert property (sel_q >= SEL_W'(1) && sel_q <= SEL_W'(NUM_SLOTS))
    else $error("slot selector outside the slot range");
endmodule
`default_nettype wire

// File: tb/net_partner.sv
`timescale 1ns/1ps
`default_nettype none
module net_partner
  import act_cmd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [3:0] stall_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [KEY_W-1:0] rx_dev_o,
  output logic [KEY_W-1:0] rx_key_o,
  output logic [KEY_W-1:0] rx_mask_o,
  output logic rx_sched_o,
  output logic [TIME_W-1:0] rx_time_o
);
  int n_tx = 0;
  int wait_q = 0;
  // quiet network at start
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_dev_o = 32'h0;
    rx_key_o = 32'h0;
    rx_mask_o = 32'h0;
    rx_sched_o = 1'b0;
    rx_time_o = 64'h0;
  end
  // one broadcast command per valid cycle, fields scrambled once idle
  task automatic send(input logic [KEY_W-1:0] d, input logic [KEY_W-1:0] k, input logic [KEY_W-1:0] m,
                      input logic s, input logic [TIME_W-1:0] t);
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b1;
    rx_dev_o <= d;
    rx_key_o <= k;
    rx_mask_o <= m;
    rx_sched_o <= s;
    rx_time_o <= t;
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_dev_o <= ~d;
    rx_key_o <= ~k;
    rx_mask_o <= ~m;
    rx_sched_o <= ~s;
    rx_time_o <= ~t;
  endtask
  // take an outgoing command after stall_i waiting cycles
  always @(posedge sys_clk_i) begin
    if (tx_ready_o && tx_valid_i) begin
      n_tx <= n_tx + 1;
      tx_ready_o <= 1'b0;
      wait_q <= 0;
    end else if (tx_valid_i) begin
      if (wait_q >= int'(stall_i)) tx_ready_o <= 1'b1;
      else wait_q <= wait_q + 1;
    end
  end
endmodule
`default_nettype wire

// File: tb/action_command_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module action_command_control_tb
  import act_cmd_pkg::*;
;
  localparam logic [31:0] UK = 32'hA5A5_0001;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic l1 = 1'b0;
  logic l2 = 1'b0;
  logic tick = 1'b1;
  logic [63:0] now = 64'h100;
  logic [3:0] stall = 4'h0;
  logic [31:0] rdata, rdev, rkey, rmask, tdk, tgk, tgm;
  logic [63:0] rtime, tet;
  logic rxv, rsch, txv, trdy, tsch, ts;
  logic [3:1] pulse;
  int n_mismatch = 0;
  int n_compared = 0;
  // clock and timestamp that counts while tick is high
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (tick) now <= now + 64'h1;
  action_command_control uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_valid_i(rxv),
    .rx_device_key_i(rdev), .rx_group_key_i(rkey), .rx_group_mask_i(rmask), .rx_scheduled_i(rsch),
    .rx_exec_time_i(rtime), .time_now_i(now), .trig_events_i(ev), .input_line_one_i(l1),
    .input_line_two_i(l2), .tx_valid_o(txv), .tx_ready_i(trdy), .tx_device_key_o(tdk),
    .tx_group_key_o(tgk), .tx_group_mask_o(tgm), .tx_scheduled_o(tsch), .tx_exec_time_o(tet),
    .action_pulse_o(pulse), .ts_reset_o(ts));
  net_partner p (.sys_clk_i(sys_clk_i), .stall_i(stall), .tx_valid_i(txv), .tx_ready_o(trdy),
    .rx_valid_o(rxv), .rx_dev_o(rdev), .rx_key_o(rkey), .rx_mask_o(rmask), .rx_sched_o(rsch),
    .rx_time_o(rtime));
  // shared compare, bus and wait helpers
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk(what, e, rdata);
  endtask
  task automatic pwait(input logic [3:1] m, output int k);
    k = 0;
    while ((pulse & m) == 3'b000 && k < 4) begin
      @(posedge sys_clk_i);
      #1 k++;
    end
  endtask
  task automatic fire(input int s, input logic lvl);
    @(posedge sys_clk_i);
    if (s <= 7) ev <= 7'(1 << (s - 1));
    else if (s == 8) l1 <= lvl;
    else l2 <= lvl;
    @(posedge sys_clk_i);
    ev <= 7'h00;
  endtask
  task automatic txchk(input logic e, input logic [63:0] ex, output int k);
    int n0;
    int j;
    k = 0;
    #1;
    while (txv !== 1'b1 && k < 5) begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    chk("tx request", e, k < 5);
    if (k < 5) begin
      chk("tx group key", 32'h33, tgk);
      chk("tx group mask", 32'h44, tgm);
      chk("tx device key", UK, tdk);
      chk("tx scheduled", ex != 0, tsch);
      chk("tx exec time", ex, tet);
      n0 = p.n_tx;
      j = 0;
      while (txv === 1'b1 && j < 20) begin
        @(posedge sys_clk_i);
        #1 j++;
      end
      chk("tx taken", n0 + 1, p.n_tx);
    end
  endtask
  // defaults, refused selector and unmapped place
  task automatic t_reset();
    rchk("slot select", OFS_SLOT_SEL, 32'(SLOT_SEL_RST));
    rchk("role", OFS_ROLE, 32'h0);
    rchk("source", OFS_SOURCE, 32'h0);
    rchk("edge", OFS_EDGE, 32'(EDGE_RST));
    rchk("unit key", OFS_UNIT_KEY, UNIT_KEY_RST);
    wreg(OFS_SLOT_SEL, 32'h0);
    wreg(8'hF0, 32'hFFFF_FFFF);
    rchk("slot select kept", OFS_SLOT_SEL, 32'h1);
    rchk("unmapped", 8'hF0, 32'h0);
  endtask
  // matching and mismatching commands on slots one and two
  task automatic t_listen();
    logic [31:0] dv[5] = '{UK, UK, UK ^ 32'h1, UK, UK};
    logic [31:0] gv[5] = '{32'h11, 32'h22, 32'h11, 32'h12, 32'h11};
    logic [31:0] mv[5] = '{32'h01, 32'h10, 32'h01, 32'h01, 32'hF0};
    logic [2:0] pe[5] = '{3'b001, 3'b010, 3'b000, 3'b000, 3'b000};
    wreg(OFS_UNIT_KEY, UK);
    wreg(OFS_GROUP_KEY, 32'h11);
    wreg(OFS_GROUP_MASK, 32'h0F);
    wreg(OFS_SLOT_SEL, 32'h2);
    wreg(OFS_GROUP_KEY, 32'h22);
    wreg(OFS_GROUP_MASK, 32'hF0);
    wreg(OFS_TS_RST, 32'h1);
    rchk("slot two key", OFS_GROUP_KEY, 32'h22);
    for (int i = 0; i < 5; i++) begin
      p.send(dv[i], gv[i], mv[i], 1'b0, 64'h0);
      #1 chk("action pulse", pe[i], pulse);
      chk("ts reset", pe[i][1], ts);
      @(posedge sys_clk_i);
      #1 chk("pulse width", 3'b000, pulse);
    end
  endtask
  // scheduled commands, future then past
  task automatic t_sched();
    int k;
    @(posedge sys_clk_i);
    tick <= 1'b0;
    @(posedge sys_clk_i);
    p.send(UK, 32'h11, 32'h01, 1'b1, now + 64'h3);
    #1 pwait(3'b001, k);
    chk("sched early", 4, k);
    @(posedge sys_clk_i);
    now <= now + 64'h3;
    #1 pwait(3'b001, k);
    chk("sched due", 1, k);
    p.send(UK, 32'h11, 32'h01, 1'b1, now - 64'h1);
    #1 pwait(3'b001, k);
    chk("sched past", 1, k);
    @(posedge sys_clk_i);
    tick <= 1'b1;
  endtask
  // originator on every event source, lead time, off
  task automatic t_orig();
    int k;
    wreg(OFS_SLOT_SEL, 32'h1);
    wreg(OFS_ROLE, 32'h1);
    rchk("role slot one", OFS_ROLE, 32'h0);
    wreg(OFS_SLOT_SEL, 32'h3);
    wreg(OFS_ROLE, 32'h1);
    wreg(OFS_GROUP_KEY, 32'h33);
    wreg(OFS_GROUP_MASK, 32'h44);
    rchk("role slot three", OFS_ROLE, 32'h1);
    for (int s = 1; s <= 7; s++) begin
      @(posedge sys_clk_i);
      stall <= 4'(s % 3);
      wreg(OFS_SOURCE, 32'(s));
      fire(s, 1'b1);
      txchk(1'b1, 64'h0, k);
      chk("tx latency", 1, k);
    end
    wreg(OFS_SOURCE, 32'h1);
    @(posedge sys_clk_i);
    tick <= 1'b0;
    wreg(OFS_LEAD, 32'h40);
    fire(1, 1'b1);
    txchk(1'b1, now + 64'h40, k);
    wreg(OFS_LEAD, 32'h0);
    tick <= 1'b1;
    wreg(OFS_SOURCE, 32'h0);
    fire(8, 1'b1);
    @(posedge sys_clk_i);
    ev <= 7'h7F;
    fire(8, 1'b0);
    txchk(1'b0, 64'h0, k);
  endtask
  // input line one on both edge choices, line two on the falling edge
  task automatic t_lines();
    int k;
    wreg(OFS_SOURCE, 32'h8);
    fire(8, 1'b1);
    txchk(1'b1, 64'h0, k);
    fire(8, 1'b0);
    txchk(1'b0, 64'h0, k);
    wreg(OFS_EDGE, 32'h0);
    fire(8, 1'b1);
    txchk(1'b0, 64'h0, k);
    fire(8, 1'b0);
    txchk(1'b1, 64'h0, k);
    wreg(OFS_SOURCE, 32'h9);
    fire(9, 1'b1);
    txchk(1'b0, 64'h0, k);
    fire(9, 1'b0);
    txchk(1'b1, 64'h0, k);
    // a second event while the request waits is dropped and flagged
    wreg(OFS_SOURCE, 32'h1);
    stall <= 4'h5;
    fire(1, 1'b1);
    fire(1, 1'b1);
    txchk(1'b1, 64'h0, k);
    rchk("status drop", OFS_STATUS, 32'h0004_0002);
    wreg(OFS_STATUS, 32'h2);
    rchk("status clear", OFS_STATUS, 32'h0004_0000);
  endtask
  // verdict
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_listen();
    t_sched();
    t_orig();
    t_lines();
    summarize();
  end
endmodule
`default_nettype wire
